// ===== design/sleep_mode_controller.sv
// Contract
// - Sleep only when sleep_allow is set at the sleep instruction; mode from select.
// - Interrupt wake stalls core four cycles after start-up, then handler runs.
// - Sleep never touches register file or static RAM contents.
// - Reset during sleep wakes device; execution starts at reset vector.
// - Idle stops only core and flash clocks, plus the timer oscillator unless timer 2 is asynchronous.
// - Idle and quiet mode start a conversion when the converter is enabled.
// - Quiet mode stops io, core and flash clocks, and the timer oscillator unless timer 2 is asynchronous; others keep running.
// - Quiet mode wakes only on the listed converter-friendly sources.
// - Power-down stops oscillator and generated clocks.
// - Power-down wakes only on resets, watchdog, address match, external or pin-change.
// - Deeper than idle, external line 0 wakes only as level interrupt.
// - Power-down wake waits start-up delay chosen by clock source fuse.
// - Power-save is power-down with timer 2 still counting.
// - Timer 2 wakes power-save only when masked in and globally enabled.
// - Power-save stops unused timer oscillator or main clock source.
// - Synchronous clock kept for timer 2 goes to timer 2 only.
// - Brown-out disable works only in power-down, power-save and standbys.
// - With brownout_sleep_off set, detector turns off right after eligible entry.
// - Brown-out detector re-enabled on every wake-up.
// - Wake after detector off extends to about 60 us.
// - brownout_sleep_off is bit 6 of core control, written via timed enable.
// - Select 110 is standby, power-down with oscillator, six-cycle wake.
// - Select 111 is extended standby, power-save with oscillator, six-cycle wake.
// - Select 100 and 101 are reserved and never enter sleep.
`timescale 1ns/1ps

module sleep_mode_controller
#(
   parameter int STARTUP_SLOW = 16384,
   parameter int STARTUP_FAST = 1024,
   parameter int DETECTOR_WAKE = sleep_pkg::DETECTOR_WAKE_CYCLES
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Core side
   input wire logic sleep_instr,
   input wire logic sleep_allow,
   input wire logic [2:0] sleep_mode_select,
   input wire logic sys_reset_req,
   input wire logic global_irq_enable,
   // Core control register write port; bit 6 holds brownout_sleep_off
   input wire logic core_ctrl_we,
   input wire logic [7:0] core_ctrl_wdata,
   input wire logic sleep_off_write_enable,
   // Configuration
   input wire logic [1:0] clock_source_fuse,
   input wire logic [1:0] timer2_irq_mask,
   input wire logic timer2_enabled,
   input wire logic timer2_async,
   input wire logic converter_enabled,
   // Wake sources
   input wire sleep_pkg::wake_src_t wake_src,
   // Clock gating outputs
   output sleep_pkg::clk_gates_t clk_run,
   // Status and control outputs
   output logic core_stall,
   output logic asleep,
   output logic brownout_enable,
   output logic conv_start,
   output logic resume_irq,
   output logic resume_reset_vector,
   output logic brownout_sleep_off
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} phase_t;

   typedef struct packed {
      phase_t phase;
      logic [2:0] mode;
      logic detector_was_off;
      logic by_reset;
      logic [sleep_pkg::CNT_W-1:0] count;
      sleep_pkg::clk_gates_t clk_run;
      logic core_stall;
      logic asleep;
      logic brownout_enable;
      logic conv_start;
      logic resume_irq;
      logic resume_reset_vector;
      logic brownout_sleep_off;
   } state_t;

   state_t st;
   state_t next_st;
   logic wake;
   logic mode_ok;
   logic detector_eligible;
   logic [sleep_pkg::CNT_W-1:0] startup;

   // ----------------------------------------------------------------
   // Wake decision
   // ----------------------------------------------------------------
   wake_filter wake_filter_i
   (
      .mode(st.mode),
      .timer2_irq_mask(timer2_irq_mask),
      .global_irq_enable(global_irq_enable),
      .src(wake_src),
      .wake(wake)
   );

   // Reserved encodings are refused so the core never stalls on them.
   always_comb
   begin
      mode_ok = (sleep_mode_select[2:1] != 2'h2);
      detector_eligible = (st.mode == sleep_pkg::MODE_PDOWN) ||
                     (st.mode == sleep_pkg::MODE_PSAVE) ||
                     (st.mode == sleep_pkg::MODE_STBY) ||
                     (st.mode == sleep_pkg::MODE_XSTBY);
   end

   // Start-up count; standby keeps the oscillator so six cycles suffice.
   always_comb
   begin
      if ((st.mode == sleep_pkg::MODE_STBY) || (st.mode == sleep_pkg::MODE_XSTBY))
         startup = sleep_pkg::CNT_W'(sleep_pkg::STANDBY_WAKE_CYCLES);
      else if ((st.mode == sleep_pkg::MODE_IDLE) || (st.mode == sleep_pkg::MODE_QUIET))
         startup = sleep_pkg::CNT_W'(1);
      else if (clock_source_fuse[1])
         startup = sleep_pkg::CNT_W'(STARTUP_SLOW);
      else
         startup = sleep_pkg::CNT_W'(STARTUP_FAST);
      if (st.detector_was_off && (startup < sleep_pkg::CNT_W'(DETECTOR_WAKE)))
         startup = sleep_pkg::CNT_W'(DETECTOR_WAKE);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Only clock enables are gated; memories keep their contents.
   always_comb
   begin
      next_st = st;
      next_st.conv_start = 1'b0;
      next_st.resume_irq = 1'b0;
      next_st.resume_reset_vector = 1'b0;
      if (core_ctrl_we && sleep_off_write_enable)
         next_st.brownout_sleep_off = core_ctrl_wdata[sleep_pkg::SLEEP_OFF_BIT];
      case (st.phase)
         ST_RUN:
         begin
            if (sleep_instr && sleep_allow && mode_ok)
            begin
               next_st.phase = ST_SLEEP;
               next_st.mode = sleep_mode_select;
               next_st.asleep = 1'b1;
               next_st.core_stall = 1'b1;
               next_st.conv_start = converter_enabled &&
                  (sleep_mode_select[2:1] == 2'h0);
            end
         end
         ST_SLEEP:
         begin
            // Detector drops one cycle after entry, once mode is registered.
            if (detector_eligible && st.brownout_sleep_off && st.brownout_enable)
            begin
               next_st.brownout_enable = 1'b0;
               next_st.detector_was_off = 1'b1;
            end
            if (sys_reset_req || wake)
            begin
               next_st.by_reset = sys_reset_req;
               next_st.phase = ST_START;
               next_st.count = 16'h0000;
               next_st.brownout_enable = 1'b1;
            end
         end
         ST_START:
         begin
            next_st.count = st.count + 16'h0001;
            if ((st.count + 16'h0001) >= startup)
            begin
               next_st.phase = ST_HALT;
               next_st.count = 16'h0000;
               next_st.asleep = 1'b0;
            end
         end
         ST_HALT:
         begin
            next_st.count = st.count + 16'h0001;
            if (st.by_reset || (st.count + 16'h0001) >= sleep_pkg::CNT_W'(sleep_pkg::HALT_CYCLES))
            begin
               next_st.phase = ST_RUN;
               next_st.core_stall = 1'b0;
               next_st.resume_irq = !st.by_reset;
               next_st.resume_reset_vector = st.by_reset;
               next_st.detector_was_off = 1'b0;
               next_st.by_reset = 1'b0;
            end
         end
         default:
            next_st.phase = ST_RUN;
      endcase
      // Clock gating per mode while asleep.
      next_st.clk_run = '1;
      if (next_st.asleep)
      begin
         next_st.clk_run.core = 1'b0;
         next_st.clk_run.flash = 1'b0;
         case (next_st.mode)
            sleep_pkg::MODE_IDLE:
               next_st.clk_run.timer_osc = timer2_async;
            sleep_pkg::MODE_QUIET:
            begin
               next_st.clk_run.io = 1'b0;
               next_st.clk_run.timer_osc = timer2_async;
            end
            default:
            begin
               // Power-down family: generated clocks stop.
               next_st.clk_run.io = 1'b0;
               next_st.clk_run.conv = 1'b0;
               next_st.clk_run.async = 1'b0;
               next_st.clk_run.main_osc = next_st.mode[2];
               next_st.clk_run.timer_osc = 1'b0;
               next_st.clk_run.t2_sync = 1'b0;
               if (next_st.mode[0] && timer2_enabled)
               begin
                  next_st.clk_run.async = timer2_async;
                  next_st.clk_run.timer_osc = timer2_async;
                  // Sync clock reaches timer 2 only, io stays off.
                  next_st.clk_run.t2_sync = !timer2_async;
                  next_st.clk_run.main_osc = next_st.mode[2] || !timer2_async;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.phase <= ST_RUN;
         st.clk_run <= '1;
         st.brownout_enable <= 1'b1;
         st.brownout_sleep_off <= sleep_pkg::CORE_CTRL_RESET[sleep_pkg::SLEEP_OFF_BIT];
      end
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs straight from the state register
   // ----------------------------------------------------------------
   assign clk_run = st.clk_run;
   assign core_stall = st.core_stall;
   assign asleep = st.asleep;
   assign brownout_enable = st.brownout_enable;
   assign conv_start = st.conv_start;
   assign resume_irq = st.resume_irq;
   assign resume_reset_vector = st.resume_reset_vector;
   assign brownout_sleep_off = st.brownout_sleep_off;

endmodule // sleep_mode_controller

// ===== design/sleep_pkg.sv
package sleep_pkg;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_QUIET = 3'h1;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_PSAVE = 3'h3;
   localparam logic [2:0] MODE_STBY = 3'h6;
   localparam logic [2:0] MODE_XSTBY = 3'h7;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SLEEP_OFF_BIT = 6;
   localparam logic [7:0] CORE_CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int HALT_CYCLES = 4;
   localparam int STANDBY_WAKE_CYCLES = 6;
   localparam int DETECTOR_WAKE_US = 60;
   localparam int DETECTOR_WAKE_CYCLES = DETECTOR_WAKE_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic core;
      logic flash;
      logic io;
      logic conv;
      logic async;
      logic main_osc;
      logic timer_osc;
      logic t2_sync;
   } clk_gates_t;

   typedef struct packed {
      logic conv_done;
      logic watchdog_irq;
      logic twi_irq;
      logic twi_addr_match;
      logic timer2_ovf;
      logic timer2_cmp;
      logic spm_ready;
      logic ee_ready;
      logic pin_change;
      logic [2:0] ext_irq_lines;
      logic ext0_is_level;
      logic other_io;
   } wake_src_t;

endpackage

// ===== design/wake_filter.sv
`timescale 1ns/1ps

// Decides whether a pending interrupt may wake the core in the given mode.
module wake_filter
(
   // Mode and enables
   input wire logic [2:0] mode,
   input wire logic [1:0] timer2_irq_mask,
   input wire logic global_irq_enable,
   // Sources
   input wire sleep_pkg::wake_src_t src,
   // Result
   output logic wake
);

   logic ext_ok;
   logic t2_ok;

   // ----------------------------------------------------------------
   // Source filtering
   // ----------------------------------------------------------------
   // Deeper than idle, line 0 only counts as a level interrupt.
   always_comb
   begin
      ext_ok = (|src.ext_irq_lines[2:1]) || (src.ext_irq_lines[0] && src.ext0_is_level);
      t2_ok = ((src.timer2_ovf && timer2_irq_mask[0]) ||
               (src.timer2_cmp && timer2_irq_mask[1])) && global_irq_enable;
      wake = 1'b0;
      case (mode)
         sleep_pkg::MODE_IDLE:
            wake = src.conv_done || src.watchdog_irq || src.twi_irq || src.twi_addr_match ||
                   src.timer2_ovf || src.timer2_cmp || src.spm_ready || src.ee_ready ||
                   src.pin_change || (|src.ext_irq_lines) || src.other_io;
         sleep_pkg::MODE_QUIET:
            wake = src.conv_done || src.watchdog_irq || src.twi_irq || src.twi_addr_match ||
                   src.timer2_ovf || src.timer2_cmp || src.spm_ready || src.ee_ready ||
                   src.pin_change || ext_ok;
         sleep_pkg::MODE_PDOWN, sleep_pkg::MODE_STBY:
            wake = src.watchdog_irq || src.twi_addr_match || src.pin_change || ext_ok;
         sleep_pkg::MODE_PSAVE, sleep_pkg::MODE_XSTBY:
            wake = src.watchdog_irq || src.twi_addr_match || src.pin_change || ext_ok || t2_ok;
         default:
            wake = 1'b0;
      endcase
   end

endmodule // wake_filter

// ===== tb/sleep_checker.sv
`timescale 1ns/1ps
// --------
// Port checks
// --------
module sleep_checker
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Core side
   input wire logic sleep_instr,
   input wire logic sleep_allow,
   input wire logic [2:0] sleep_mode_select,
   input wire logic sys_reset_req,
   input wire logic core_ctrl_we,
   input wire logic [7:0] core_ctrl_wdata,
   input wire logic sleep_off_write_enable,
   // Outputs
   input wire sleep_pkg::clk_gates_t clk_run,
   input wire logic core_stall,
   input wire logic asleep,
   input wire logic brownout_enable,
   input wire logic resume_irq,
   input wire logic resume_reset_vector,
   input wire logic brownout_sleep_off
);
   // One clock domain, so reset silences every check at once.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_refused_no_sleep: assert property (sleep_instr && !sleep_allow && !core_stall |=> !asleep)
      else $error("sleep taken without permission");
   a_reserved_no_sleep: assert property (sleep_instr && sleep_mode_select[2:1] == 2'h2 && !core_stall |=> !asleep)
      else $error("sleep taken on reserved select");
   a_sleep_entry: assert property (sleep_instr && sleep_allow && sleep_mode_select[2:1] != 2'h2 && !core_stall |=> asleep && core_stall)
      else $error("sleep not entered");
   a_idle_gates: assert property ($rose(asleep) && $past(sleep_mode_select) == sleep_pkg::MODE_IDLE |-> !clk_run.core && !clk_run.flash && clk_run.io && clk_run.conv)
      else $error("idle clock gating wrong");
   a_detector_off: assert property ($rose(asleep) && $past(sleep_mode_select[1]) && brownout_sleep_off |=> !brownout_enable)
      else $error("detector not switched off");
   a_detector_kept: assert property ($rose(asleep) && !$past(sleep_mode_select[1]) |=> brownout_enable)
      else $error("detector off in shallow sleep");
   a_detector_restored: assert property ($fell(asleep) |-> brownout_enable)
      else $error("detector not back on wake");
   a_halt_four: assert property ($fell(asleep) && !sys_reset_req && !$past(sys_reset_req) |-> core_stall [*4] ##1 (!core_stall && resume_irq))
      else $error("halt after wake not four cycles");
   a_reset_vector: assert property (asleep && sys_reset_req |-> ##[1:60] resume_reset_vector)
      else $error("reset wake missing");
   a_sleep_off_write: assert property (core_ctrl_we && sleep_off_write_enable |=> brownout_sleep_off == $past(core_ctrl_wdata[sleep_pkg::SLEEP_OFF_BIT]))
      else $error("detector sleep bit not written");
endmodule // sleep_checker

bind sleep_mode_controller sleep_checker sleep_checker_i (.sys_clk(sys_clk), .rstn(rstn),
   .sleep_instr(sleep_instr), .sleep_allow(sleep_allow), .sleep_mode_select(sleep_mode_select),
   .sys_reset_req(sys_reset_req), .core_ctrl_we(core_ctrl_we), .core_ctrl_wdata(core_ctrl_wdata),
   .sleep_off_write_enable(sleep_off_write_enable), .clk_run(clk_run), .core_stall(core_stall),
   .asleep(asleep), .brownout_enable(brownout_enable), .resume_irq(resume_irq),
   .resume_reset_vector(resume_reset_vector), .brownout_sleep_off(brownout_sleep_off));

// ===== tb/test_sleep_mode_controller.sv
`timescale 1ns/1ps
// --------
// Bench
// --------
module test_sleep_mode_controller;
   // Bit positions inside the packed wake source carrier.
   localparam int CD = 13, OVF = 9, CMP = 8, PC = 5, E0 = 2, LVL = 1, IO = 0;
   logic sys_clk = 1'b0, rstn = 1'b0, sleep_instr = 1'b0, sleep_allow = 1'b1, fire = 1'b0;
   logic sys_reset_req = 1'b0, global_irq_enable = 1'b1, core_ctrl_we = 1'b0, timer2_async = 1'b1;
   logic sleep_off_write_enable = 1'b0, timer2_enabled = 1'b1, converter_enabled = 1'b1, cs, bo;
   logic [2:0] sleep_mode_select = 3'h0;
   logic [7:0] core_ctrl_wdata = 8'h00;
   logic [1:0] clock_source_fuse = 2'h0, timer2_irq_mask = 2'h3;
   sleep_pkg::wake_src_t wake_src, pattern = '0;
   sleep_pkg::clk_gates_t clk_run, g;
   logic core_stall, asleep, brownout_enable, conv_start, resume_irq, resume_reset_vector, bso;
   int n_fail = 0, total_checks = 0, cycles = 0, t = 0, t_idle = 0, t_pd = 0;

   // Short start-up counts keep the run brief; all expectations derive from them.
   sleep_mode_controller #(.STARTUP_SLOW(20), .STARTUP_FAST(10), .DETECTOR_WAKE(30))
      sleep_mode_controller_i
   (.sys_clk(sys_clk), .rstn(rstn), .sleep_instr(sleep_instr), .sleep_allow(sleep_allow),
    .sleep_mode_select(sleep_mode_select), .sys_reset_req(sys_reset_req),
    .global_irq_enable(global_irq_enable), .core_ctrl_we(core_ctrl_we),
    .core_ctrl_wdata(core_ctrl_wdata), .sleep_off_write_enable(sleep_off_write_enable),
    .clock_source_fuse(clock_source_fuse), .timer2_irq_mask(timer2_irq_mask),
    .timer2_enabled(timer2_enabled), .timer2_async(timer2_async),
    .converter_enabled(converter_enabled), .wake_src(wake_src), .clk_run(clk_run),
    .core_stall(core_stall), .asleep(asleep), .brownout_enable(brownout_enable),
    .conv_start(conv_start), .resume_irq(resume_irq), .resume_reset_vector(resume_reset_vector),
    .brownout_sleep_off(bso));
   wake_source_model wake_source_model_i (.sys_clk(sys_clk), .rstn(rstn), .fire(fire),
      .pattern(pattern), .asleep(asleep), .wake_src(wake_src));

   // Clock of 40 ns.
   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end

   // A hang counts as a mismatch and ends the run.
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic sleep_pkg::wake_src_t w(input int f);
      w = '0;
      w[f] = 1'b1;
   endfunction

   task automatic fire_src(input sleep_pkg::wake_src_t p);
      @(posedge sys_clk);
      pattern <= p;
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
   endtask

   // Sleeps, offers a source that must not wake, then one that must; t is the wake time.
   task automatic nap(input logic [2:0] m, input sleep_pkg::wake_src_t bad, good);
      @(posedge sys_clk);
      sleep_mode_select <= m;
      sleep_instr <= 1'b1;
      @(posedge sys_clk);
      sleep_instr <= 1'b0;
      #1;
      g = clk_run;
      cs = conv_start;
      chk("asleep", 16'h1, 16'(asleep));
      @(posedge sys_clk);
      #1;
      bo = brownout_enable;
      if (bad != '0)
      begin
         fire_src(bad);
         repeat (12) @(posedge sys_clk);
         #1;
         chk("held asleep", 16'h1, 16'(asleep));
      end
      fire_src(good);
      t = 0;
      while (asleep && t < 200)
      begin
         @(posedge sys_clk);
         #1;
         t++;
      end
      chk("woke", 16'h0, 16'(asleep));
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic write_ctrl(input logic [7:0] v, input logic en);
      @(posedge sys_clk);
      core_ctrl_we <= 1'b1;
      core_ctrl_wdata <= v;
      sleep_off_write_enable <= en;
      @(posedge sys_clk);
      core_ctrl_we <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic t_refuse();
      for (int i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         sleep_allow <= (i != 0);
         sleep_mode_select <= (i == 0) ? 3'h0 : 3'(3 + i);
         sleep_instr <= 1'b1;
         @(posedge sys_clk);
         sleep_instr <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1;
         chk("refused", 16'h0, 16'(asleep));
      end
      @(posedge sys_clk);
      sleep_allow <= 1'b1;
   endtask

   task automatic t_shallow();
      nap(sleep_pkg::MODE_IDLE, '0, w(PC));
      t_idle = t;
      chk("idle gates", 16'h03, 16'({g.core, g.flash, g.io, g.conv}));
      chk("idle conversion", 16'h1, 16'(cs));
      nap(sleep_pkg::MODE_QUIET, w(IO), w(CD));
      chk("quiet gates", 16'h01, 16'({g.io, g.core, g.flash, g.conv}));
      chk("quiet conversion", 16'h1, 16'(cs));
   endtask

   task automatic t_standby();
      nap(sleep_pkg::MODE_STBY, '0, w(PC));
      chk("standby wake", 16'h5, 16'(t - t_idle));
      chk("standby osc", 16'h1, 16'(g.main_osc));
      nap(sleep_pkg::MODE_XSTBY, '0, w(PC));
      chk("ext standby wake", 16'h5, 16'(t - t_idle));
   endtask

   task automatic t_pdown();
      nap(sleep_pkg::MODE_PDOWN, w(E0) | w(OVF), w(PC));
      t_pd = t;
      chk("pdown gates", 16'h0, 16'({g.main_osc, g.io, g.conv, g.core}));
      chk("pdown conversion", 16'h0, 16'(cs));
      clock_source_fuse <= 2'h2;
      nap(sleep_pkg::MODE_PDOWN, '0, w(E0) | w(LVL));
      chk("slow start", 16'hA, 16'(t - t_pd));
      clock_source_fuse <= 2'h0;
   endtask

   task automatic t_psave();
      timer2_irq_mask <= 2'h1;
      nap(sleep_pkg::MODE_PSAVE, w(CMP), w(OVF));
      chk("async save osc", 16'h1, 16'({g.main_osc, g.timer_osc}));
      timer2_async <= 1'b0;
      // With the global enable clear, a masked-in overflow must not wake.
      global_irq_enable <= 1'b0;
      nap(sleep_pkg::MODE_PSAVE, w(OVF), w(PC));
      global_irq_enable <= 1'b1;
      chk("sync save osc", 16'h0, 16'(g.timer_osc));
      chk("sync save route", 16'h2, 16'({g.t2_sync, g.io}));
   endtask

   task automatic t_brownout_sleep_off();
      write_ctrl(8'h40, 1'b1);
      chk("sleep off set", 16'h1, 16'(bso));
      write_ctrl(8'h00, 1'b0);
      chk("sleep off guarded", 16'h1, 16'(bso));
      nap(sleep_pkg::MODE_PDOWN, '0, w(PC));
      chk("detector off", 16'h0, 16'(bo));
      chk("detector on", 16'h1, 16'(brownout_enable));
      chk("long wake", 16'h14, 16'(t - t_pd));
      nap(sleep_pkg::MODE_IDLE, '0, w(PC));
      chk("idle detector", 16'h1, 16'(bo));
      write_ctrl(8'h00, 1'b1);
   endtask

   task automatic t_reset_wake();
      @(posedge sys_clk);
      sleep_mode_select <= sleep_pkg::MODE_PDOWN;
      sleep_instr <= 1'b1;
      @(posedge sys_clk);
      sleep_instr <= 1'b0;
      repeat (3) @(posedge sys_clk);
      sys_reset_req <= 1'b1;
      t = 0;
      while (resume_reset_vector !== 1'b1 && t < 100)
      begin
         @(posedge sys_clk);
         #1;
         t++;
      end
      chk("reset vector", 16'h1, 16'(resume_reset_vector));
      @(posedge sys_clk);
      sys_reset_req <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask

   // Main sequence.
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      t_refuse();
      t_shallow();
      t_standby();
      t_pdown();
      t_psave();
      t_brownout_sleep_off();
      t_reset_wake();
      conclude();
   end
endmodule // test_sleep_mode_controller

// ===== tb/wake_source_model.sv
`timescale 1ns/1ps
// --------
// Interrupt sources
// --------
module wake_source_model
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Requests and controller state
   input wire logic fire,
   input wire sleep_pkg::wake_src_t pattern,
   input wire logic asleep,
   // Pending sources
   output sleep_pkg::wake_src_t wake_src
);
   logic was_asleep;
   // A source holds its level until the core has left sleep, so a slow start-up never loses it.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wake_src <= '0;
         was_asleep <= 1'b0;
      end
      else
      begin
         was_asleep <= asleep;
         if (fire)
            wake_src <= wake_src | pattern;
         else if (was_asleep && !asleep)
            wake_src <= '0;
      end
   end
endmodule // wake_source_model
